// *** hdl/host_uart_i2c_register_port.sv ***
`timescale 1ns/1ns
// Functional notes
// - exponent zero gives bit time of divider plus one system clock ticks.
// - nonzero exponent gives divider plus 33 ticks, times two to exponent minus one.
// - uart character is start 0, eight data bits lsb first, stop 1.
// - uart read takes an access byte and returns the addressed data byte.
// - uart write takes access byte and data byte, echoing the access byte.
// - data byte may arrive before the echo has finished.
// - i2c side is a slave only, never clocks, never arbitrates.
// - scl is never held low by this port.
// - no general call, no bus reset, no device id, no high speed.
// - logic keeps up with fast-plus rates up to 1 Mbit/s.
// - spike filter on scl and sda runs whenever i2c mode is selected.
// - sda changes only while scl is low, outside start and stop.
// - start is sda falling with scl high, stop is sda rising.
// - repeated start restarts address recognition like a start.
// - i2c bytes go msb first, each followed by one acknowledge bit.
// - transmitter releases sda on acknowledge, receiver pulls it low.
// - on master nack the slave releases sda until stop or start.
// - slave address is 01010 followed by two pin or nonvolatile bits.
// - i2c write is address with rw 0, register byte, then data bytes.
// - writes aimed at the fifo all go to the fifo address.
// - i2c read returns successive registers from the pointer, fifo not stepped.
module host_uart_i2c_register_port
   import host_port_pkg::*;
(
   input wire logic core_clk_in,              // core clock
   input wire logic rst_n_in,                 // sync reset, low active
   input wire logic i2c_mode_in,              // 1 i2c host mode, 0 uart
   input wire logic [7:0] serial_speed_setting_in, // uart speed byte
   input wire logic uart_read_trigger_pin_in, // uart read enable
   input wire logic uart_rx_in,               // uart receive line
   output logic uart_tx_out,                  // uart transmit line
   input wire logic scl_in,                   // i2c clock, input only
   input wire logic sda_in,                   // i2c data level
   output logic sda_out,                      // i2c data drive value
   output logic sda_oe_n_out,                 // i2c data enable, low drives
   input wire logic [1:0] adr_pins_in,        // address select pins
   input wire logic [1:0] adr_nv_in,          // nonvolatile address bits
   input wire logic adr_use_nv_in,            // 1 takes nonvolatile bits
   output logic [6:0] reg_addr_out,           // register pointer
   output logic [7:0] reg_wdata_out,          // write data
   output logic reg_wr_out,                   // write strobe
   output logic reg_rd_out,                   // read strobe, data consumed
   input wire logic [7:0] reg_rdata_in        // data at reg_addr_out
);
   // ----------------------------------------------------------------
   // uart byte engine
   // ----------------------------------------------------------------
   uart_link_if link ();

   uart_phy u_phy (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .rx_in(uart_rx_in),
      .tx_out(uart_tx_out),
      .link(link)
   );

   // ----------------------------------------------------------------
   // spike filter
   // ----------------------------------------------------------------
   logic scl_f, next_scl_f, sda_f, next_sda_f;
   logic [4:0] scl_cnt, next_scl_cnt, sda_cnt, next_sda_cnt;
   logic scl_p, sda_p;

   always_comb
   begin
      next_scl_f = scl_f;
      next_sda_f = sda_f;
      next_scl_cnt = 5'h00;
      next_sda_cnt = 5'h00;
      // a change must hold past the spike time before it is believed
      if (!i2c_mode_in)
      begin
         next_scl_f = 1'b1;
         next_sda_f = 1'b1;
      end
      else
      begin
         if (scl_in != scl_f)
         begin
            next_scl_cnt = scl_cnt + 5'h01;
            if (scl_cnt >= SPIKE_CYC)
            begin
               next_scl_f = scl_in;
               next_scl_cnt = 5'h00;
            end
         end
         if (sda_in != sda_f)
         begin
            next_sda_cnt = sda_cnt + 5'h01;
            if (sda_cnt >= SPIKE_CYC)
            begin
               next_sda_f = sda_in;
               next_sda_cnt = 5'h00;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_cnt <= 5'h00;
         sda_cnt <= 5'h00;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end
      else
      begin
         scl_f <= next_scl_f;
         sda_f <= next_sda_f;
         scl_cnt <= next_scl_cnt;
         sda_cnt <= next_sda_cnt;
         scl_p <= scl_f;
         sda_p <= sda_f;
      end
   end

   logic scl_rise, scl_fall, start_seen, stop_seen;
   assign scl_rise = scl_f & ~scl_p;
   assign scl_fall = ~scl_f & scl_p;
   assign start_seen = scl_f & scl_p & sda_p & ~sda_f;
   assign stop_seen = scl_f & scl_p & ~sda_p & sda_f;

   // ----------------------------------------------------------------
   // transfer control, shared pointer for both host modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_RECV = 3'b001,
      ST_ACK_OUT = 3'b010,
      ST_SEND = 3'b011,
      ST_ACK_IN = 3'b100,
      ST_U_WDATA = 3'b101,
      ST_U_READ = 3'b110
   } state_t;

   state_t state, next_state;
   byte_kind_t kind, next_kind;
   logic [7:0] sh, next_sh;
   logic [3:0] cnt, next_cnt;
   logic rd_mode, next_rd_mode;
   logic master_ack, next_master_ack;
   logic drive_low, next_drive_low;
   logic [6:0] ptr, next_ptr;
   logic [7:0] wdata, next_wdata;
   logic wr, next_wr, rd, next_rd;
   logic [7:0] tx_data, next_tx_data;
   logic tx_start, next_tx_start;
   logic [6:0] my_addr;

   assign my_addr = {I2C_ADDR_HI, adr_use_nv_in ? adr_nv_in : adr_pins_in};

   always_comb
   begin
      next_state = state;
      next_kind = kind;
      next_sh = sh;
      next_cnt = cnt;
      next_rd_mode = rd_mode;
      next_master_ack = master_ack;
      next_drive_low = drive_low;
      next_ptr = ptr;
      next_wdata = wdata;
      next_wr = 1'b0;
      next_rd = 1'b0;
      next_tx_data = tx_data;
      next_tx_start = 1'b0;
      if (!i2c_mode_in)
      begin
         next_drive_low = 1'b0;
         case (state)
            ST_U_WDATA:
            begin
               // the echo may still be on the line, reception runs apart
               if (link.rx_valid)
               begin
                  next_wdata = link.rx_data;
                  next_wr = 1'b1;
                  next_state = ST_IDLE;
               end
            end
            ST_U_READ:
            begin
               next_tx_data = reg_rdata_in;
               next_tx_start = 1'b1;
               next_rd = 1'b1;
               next_state = ST_IDLE;
            end
            default:
            begin
               next_state = ST_IDLE;
               if (link.rx_valid)
               begin
                  next_ptr = link.rx_data[7:1];
                  if (link.rx_data[MODE_BIT] == MODE_READ)
                  begin
                     if (uart_read_trigger_pin_in)
                        next_state = ST_U_READ;
                  end
                  else
                  begin
                     next_tx_data = link.rx_data;
                     next_tx_start = 1'b1;
                     next_state = ST_U_WDATA;
                  end
               end
            end
         endcase
      end
      else if (stop_seen)
      begin
         next_state = ST_IDLE;
         next_drive_low = 1'b0;
      end
      else if (start_seen)
      begin
         // repeated start is handled the same as a first start
         next_state = ST_RECV;
         next_kind = KIND_ADDR;
         next_cnt = 4'h0;
         next_drive_low = 1'b0;
      end
      else
      begin
         // sda only ever moves on a falling scl edge; scl is never driven
         case (state)
            ST_RECV:
            begin
               if (scl_rise)
               begin
                  next_sh = {sh[6:0], sda_f};
                  next_cnt = cnt + 4'h1;
               end
               else if (scl_fall && cnt == I2C_BYTE_BITS)
               begin
                  next_state = ST_ACK_OUT;
                  next_drive_low = 1'b1;
                  case (kind)
                     KIND_ADDR:
                     begin
                        next_rd_mode = sh[0];
                        // general call and foreign addresses are not answered
                        if (sh[7:1] != my_addr)
                        begin
                           next_state = ST_IDLE;
                           next_drive_low = 1'b0;
                        end
                     end
                     KIND_REG:
                        next_ptr = sh[6:0];
                     default:
                     begin
                        next_wdata = sh;
                        next_wr = 1'b1;
                     end
                  endcase
               end
            end
            ST_ACK_OUT:
            begin
               if (scl_fall)
               begin
                  next_drive_low = 1'b0;
                  if (kind == KIND_DATA)
                     next_ptr = step_ptr(ptr);
                  if (kind == KIND_ADDR && rd_mode)
                  begin
                     next_sh = reg_rdata_in;
                     next_rd = 1'b1;
                     next_state = ST_SEND;
                     next_cnt = 4'h0;
                     next_drive_low = ~reg_rdata_in[7];
                  end
                  else
                  begin
                     next_state = ST_RECV;
                     next_cnt = 4'h0;
                     next_kind = (kind == KIND_ADDR) ? KIND_REG : KIND_DATA;
                  end
               end
            end
            ST_SEND:
            begin
               if (scl_rise)
                  next_cnt = cnt + 4'h1;
               else if (scl_fall)
               begin
                  if (cnt == I2C_BYTE_BITS)
                  begin
                     next_drive_low = 1'b0;
                     next_state = ST_ACK_IN;
                     next_ptr = step_ptr(ptr);
                  end
                  else
                  begin
                     next_sh = {sh[6:0], 1'b0};
                     next_drive_low = ~sh[6];
                  end
               end
            end
            ST_ACK_IN:
            begin
               if (scl_rise)
                  next_master_ack = ~sda_f;
               else if (scl_fall)
               begin
                  if (master_ack)
                  begin
                     next_sh = reg_rdata_in;
                     next_rd = 1'b1;
                     next_cnt = 4'h0;
                     next_state = ST_SEND;
                     next_drive_low = ~reg_rdata_in[7];
                  end
                  else
                     next_state = ST_IDLE;
               end
            end
            default:
               next_drive_low = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         state <= ST_IDLE;
         kind <= KIND_ADDR;
         sh <= 8'h00;
         cnt <= 4'h0;
         rd_mode <= 1'b0;
         master_ack <= 1'b0;
         drive_low <= 1'b0;
         ptr <= 7'h00;
         wdata <= 8'h00;
         wr <= 1'b0;
         rd <= 1'b0;
         tx_data <= 8'h00;
         tx_start <= 1'b0;
      end
      else
      begin
         state <= next_state;
         kind <= next_kind;
         sh <= next_sh;
         cnt <= next_cnt;
         rd_mode <= next_rd_mode;
         master_ack <= next_master_ack;
         drive_low <= next_drive_low;
         ptr <= next_ptr;
         wdata <= next_wdata;
         wr <= next_wr;
         rd <= next_rd;
         tx_data <= next_tx_data;
         tx_start <= next_tx_start;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.speed = serial_speed_setting_in;
   assign link.tx_data = tx_data;
   assign link.tx_start = tx_start;
   assign sda_out = 1'b0;
   assign sda_oe_n_out = ~drive_low;
   assign reg_addr_out = ptr;
   assign reg_wdata_out = wdata;
   assign reg_wr_out = wr;
   assign reg_rd_out = rd;
endmodule : host_uart_i2c_register_port

// *** hdl/host_port_pkg.sv ***
package host_port_pkg;
   // ----------------------------------------------------------------
   // clocks and timing
   // ----------------------------------------------------------------
   localparam int CORE_CLK_KHZ = 250000;
   localparam int SYS_CLK_KHZ = 27120;
   localparam int CORE_CLK_MHZ = 250;
   localparam int SPIKE_NS = 50;
   localparam logic [4:0] SPIKE_CYC = 5'(SPIKE_NS * CORE_CLK_MHZ / 1000);
   localparam int MAX_UART_KBPS = 1229;
   // ----------------------------------------------------------------
   // serial speed setting layout
   // ----------------------------------------------------------------
   localparam int SPD_EXP_MSB = 7;
   localparam int SPD_EXP_LSB = 5;
   localparam int SPD_DIV_MSB = 4;
   localparam int SPD_DIV_LSB = 0;
   localparam logic [12:0] SPD_ZERO_ADD = 13'h0001;
   localparam logic [12:0] SPD_EXP_ADD = 13'h0021;
   // ----------------------------------------------------------------
   // uart character
   // ----------------------------------------------------------------
   localparam logic [3:0] UART_FRAME_BITS = 4'hA;
   localparam logic UART_START_BIT = 1'b0;
   localparam logic UART_STOP_BIT = 1'b1;
   // ----------------------------------------------------------------
   // access byte and i2c addressing
   // ----------------------------------------------------------------
   localparam int MODE_BIT = 0;
   localparam logic MODE_READ = 1'b1;
   localparam logic [4:0] I2C_ADDR_HI = 5'h0A;
   localparam logic [6:0] FIFO_ADDR = 7'h05;
   localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

   typedef enum logic [1:0]
   {
      KIND_ADDR = 2'b00,
      KIND_REG = 2'b01,
      KIND_DATA = 2'b10
   } byte_kind_t;

   // bit time in system clock ticks
   function automatic logic [12:0] bit_ticks(input logic [7:0] setting);
      logic [2:0] e;
      logic [12:0] d;
      e = setting[SPD_EXP_MSB:SPD_EXP_LSB];
      d = {8'h00, setting[SPD_DIV_MSB:SPD_DIV_LSB]};
      if (e == 3'h0)
         bit_ticks = d + SPD_ZERO_ADD;
      else
         bit_ticks = 13'((d + SPD_EXP_ADD) << (e - 3'h1));
   endfunction : bit_ticks

   function automatic logic [6:0] step_ptr(input logic [6:0] ptr);
      step_ptr = (ptr == FIFO_ADDR) ? ptr : 7'(ptr + 7'h01);
   endfunction : step_ptr
endpackage : host_port_pkg

// *** hdl/uart_link_if.sv ***
`timescale 1ns/1ns
interface uart_link_if;
   logic [7:0] speed;
   logic [7:0] tx_data;
   logic tx_start;
   logic tx_busy;
   logic [7:0] rx_data;
   logic rx_valid;
   modport core (output speed, output tx_data, output tx_start, input tx_busy,
      input rx_data, input rx_valid);
   modport phy (input speed, input tx_data, input tx_start, output tx_busy,
      output rx_data, output rx_valid);
endinterface : uart_link_if

// *** hdl/uart_phy.sv ***
`timescale 1ns/1ns
module uart_phy
   import host_port_pkg::*;
(
   input wire logic core_clk_in,      // core clock
   input wire logic rst_n_in,         // sync reset, low active
   input wire logic rx_in,            // serial receive line
   output logic tx_out,               // serial transmit line
   uart_link_if.phy link              // byte side
);
   // ----------------------------------------------------------------
   // system clock tick, fractional rate from the core clock
   // ----------------------------------------------------------------
   logic [17:0] acc, next_acc;
   logic [18:0] acc_sum;
   logic sys_tick;
   logic [12:0] ticks;

   always_comb
   begin
      ticks = bit_ticks(link.speed);
      // one bit wider than the accumulator so the sum can never wrap
      acc_sum = {1'b0, acc} + 19'(SYS_CLK_KHZ);
      sys_tick = acc_sum >= 19'(CORE_CLK_KHZ);
      next_acc = sys_tick ? 18'(acc_sum - 19'(CORE_CLK_KHZ)) : acc_sum[17:0];
   end

   // ----------------------------------------------------------------
   // transmitter and receiver
   // ----------------------------------------------------------------
   logic [9:0] tx_sh, next_tx_sh;
   logic [3:0] tx_cnt, next_tx_cnt;
   logic [12:0] tx_tk, next_tx_tk;
   logic [7:0] rx_sh, next_rx_sh;
   logic [3:0] rx_cnt, next_rx_cnt;
   logic [12:0] rx_tk, next_rx_tk;
   logic [7:0] rx_data, next_rx_data;
   logic rx_valid, next_rx_valid;

   always_comb
   begin
      next_tx_sh = tx_sh;
      next_tx_cnt = tx_cnt;
      next_tx_tk = tx_tk;
      if (tx_cnt == 4'h0)
      begin
         if (link.tx_start)
         begin
            // lsb first after the start bit, one stop bit, no parity
            next_tx_sh = {UART_STOP_BIT, link.tx_data, UART_START_BIT};
            next_tx_cnt = UART_FRAME_BITS;
            next_tx_tk = 13'h0000;
         end
      end
      else if (sys_tick)
      begin
         if (tx_tk + 13'h0001 >= ticks)
         begin
            next_tx_tk = 13'h0000;
            next_tx_sh = {1'b1, tx_sh[9:1]};
            next_tx_cnt = tx_cnt - 4'h1;
         end
         else
            next_tx_tk = tx_tk + 13'h0001;
      end

      next_rx_sh = rx_sh;
      next_rx_cnt = rx_cnt;
      next_rx_tk = rx_tk;
      next_rx_data = rx_data;
      next_rx_valid = 1'b0;
      if (rx_cnt == 4'h0)
      begin
         if (rx_in == UART_START_BIT)
         begin
            next_rx_cnt = UART_FRAME_BITS;
            // first sample lands mid start bit
            next_rx_tk = ticks >> 1;
         end
      end
      else if (sys_tick)
      begin
         if (rx_tk + 13'h0001 >= ticks)
         begin
            next_rx_tk = 13'h0000;
            next_rx_cnt = rx_cnt - 4'h1;
            if (rx_cnt == UART_FRAME_BITS && rx_in != UART_START_BIT)
               next_rx_cnt = 4'h0; // glitch, not a start
            else if (rx_cnt == 4'h1)
            begin
               next_rx_valid = (rx_in == UART_STOP_BIT);
               next_rx_data = rx_sh;
            end
            else if (rx_cnt != UART_FRAME_BITS)
               next_rx_sh = {rx_in, rx_sh[7:1]};
         end
         else
            next_rx_tk = rx_tk + 13'h0001;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         acc <= 18'h00000;
         tx_sh <= 10'h3FF;
         tx_cnt <= 4'h0;
         tx_tk <= 13'h0000;
         rx_sh <= 8'h00;
         rx_cnt <= 4'h0;
         rx_tk <= 13'h0000;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
      end
      else
      begin
         acc <= next_acc;
         tx_sh <= next_tx_sh;
         tx_cnt <= next_tx_cnt;
         tx_tk <= next_tx_tk;
         rx_sh <= next_rx_sh;
         rx_cnt <= next_rx_cnt;
         rx_tk <= next_rx_tk;
         rx_data <= next_rx_data;
         rx_valid <= next_rx_valid;
      end
   end

   assign tx_out = tx_sh[0];
   assign link.tx_busy = (tx_cnt != 4'h0);
   assign link.rx_data = rx_data;
   assign link.rx_valid = rx_valid;
endmodule : uart_phy

// *** verification/host_port_monitor.sv ***
`timescale 1ns/1ns
module host_port_monitor
(
   input wire logic core_clk_in, // clock
   input wire logic rst_n_in, // reset
   input wire logic i2c_mode_in, // mode
   input wire logic uart_read_trigger_pin_in, // trigger
   input wire logic uart_tx_out, // tx
   input wire logic scl_in, // scl
   input wire logic sda_oe_n_out, // drive
   input wire logic reg_wr_out, // write
   input wire logic reg_rd_out // read
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_wr_pulse: assert property (reg_wr_out |=> !reg_wr_out)
      else $error("write strobe too long");
   a_rd_pulse: assert property (reg_rd_out |=> !reg_rd_out)
      else $error("read strobe too long");
   a_sda_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
      else $error("sda moved with scl high");
   a_drive_hold: assert property ($fell(sda_oe_n_out) |=> (!sda_oe_n_out)[*8])
      else $error("sda drive too short");
   a_wr_acked: assert property (reg_wr_out && i2c_mode_in |-> !sda_oe_n_out)
      else $error("write without ack");
   a_uart_sda_free: assert property (!i2c_mode_in |-> sda_oe_n_out)
      else $error("sda driven in uart mode");
   a_rd_sends: assert property (reg_rd_out && !i2c_mode_in |-> ##[1:2] !uart_tx_out)
      else $error("read data not sent");
   a_rd_trigger: assert property (!i2c_mode_in && !uart_read_trigger_pin_in |-> !reg_rd_out)
      else $error("read without trigger");
endmodule : host_port_monitor
bind host_uart_i2c_register_port host_port_monitor i_mon (.core_clk_in, .rst_n_in, .i2c_mode_in,
   .uart_read_trigger_pin_in, .uart_tx_out, .scl_in, .sda_oe_n_out, .reg_wr_out, .reg_rd_out);

// *** verification/host_model.sv ***
`timescale 1ns/1ns
module host_model
(
   input wire logic core_clk_in, // clock
   input wire logic tx_line_in, // device tx
   input wire logic sda_in, // sda wire
   output logic rx_line_out, // device rx
   output logic scl_out, // scl
   output logic sda_drv_out // low pulls sda
);
   int bt = 202;
   int q = 63;
   initial {rx_line_out, scl_out, sda_drv_out} = 3'h7;
   task automatic tk(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : tk
   task automatic uart_put(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rx_line_out = f[i];
         tk(bt);
      end
   endtask : uart_put
   // gives up after 25 bits so a silent device cannot hang the run
   task automatic uart_get(output logic [8:0] b);
      int w = 0;
      b = 9'h000;
      while (tx_line_in !== 1'b0 && w < 25 * bt)
      begin
         tk(1);
         w++;
      end
      if (w < 25 * bt)
      begin
         tk(bt / 2);
         for (int i = 0; i < 9; i++)
         begin
            tk(bt);
            b[i] = tx_line_in;
         end
      end
   endtask : uart_get
   // ----------------
   // i2c master
   // ----------------
   task automatic st(input logic c, input logic d);
      scl_out = c;
      sda_drv_out = d;
      tk(q);
   endtask : st
   task automatic i2c_s();
      st(scl_out, 1'b1);
      st(1'b1, 1'b1);
      st(1'b1, 1'b0);
      st(1'b0, 1'b0);
   endtask : i2c_s
   task automatic i2c_p();
      st(1'b0, 1'b0);
      st(1'b1, 1'b0);
      st(1'b1, 1'b1);
   endtask : i2c_p
   task automatic i2c_bit(input logic o, output logic i);
      st(1'b0, o);
      st(1'b1, o);
      i = sda_in;
      st(1'b1, o);
      st(1'b0, o);
   endtask : i2c_bit
   // m_ack high leaves sda released on the ninth clock
   task automatic i2c_byte(input logic [7:0] o, input logic m_ack, output logic [7:0] i,
      output logic a);
      for (int k = 7; k >= 0; k--)
         i2c_bit(o[k], i[k]);
      i2c_bit(m_ack, a);
   endtask : i2c_byte
endmodule : host_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
module tb_top
   import host_port_pkg::*;
;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic i2c_mode_in = 1'b0;
   logic [7:0] serial_speed_setting_in = 8'h15;
   logic uart_read_trigger_pin_in = 1'b1;
   logic [1:0] adr_pins_in = 2'h0;
   logic [1:0] adr_nv_in = 2'h0;
   logic adr_use_nv_in = 1'b0;
   logic uart_rx_in, uart_tx_out, scl_in, sda_in, sda_out, sda_oe_n_out, sda_drv;
   logic reg_wr_out, reg_rd_out;
   logic [6:0] reg_addr_out;
   logic [7:0] reg_wdata_out, reg_rdata_in;
   logic [14:0] wq [$];
   logic [7:0] spd [2] = '{8'h15, 8'h3A};
   int fail_count = 0;
   int cmp_count = 0;
   function automatic logic [7:0] mem_val(input logic [6:0] x);
      return {x, 1'b1} ^ 8'h5A;
   endfunction : mem_val
   function automatic int bit_cyc(input logic [7:0] s);
      int t;
      t = (s[7:5] == 3'h0) ? s[4:0] + 1 : (s[4:0] + 33) << (s[7:5] - 1);
      return t * CORE_CLK_KHZ / SYS_CLK_KHZ;
   endfunction : bit_cyc
   always #2 core_clk_in = ~core_clk_in;
   // wired and stands in for the pull-up
   assign sda_in = sda_drv & (sda_oe_n_out | sda_out);
   assign reg_rdata_in = mem_val(reg_addr_out);
   always @(posedge core_clk_in)
      if (reg_wr_out === 1'b1)
         wq.push_back({reg_addr_out, reg_wdata_out});
   host_uart_i2c_register_port i_dut (.core_clk_in, .rst_n_in, .i2c_mode_in,
      .serial_speed_setting_in, .uart_read_trigger_pin_in, .uart_rx_in, .uart_tx_out, .scl_in,
      .sda_in, .sda_out, .sda_oe_n_out, .adr_pins_in, .adr_nv_in, .adr_use_nv_in, .reg_addr_out,
      .reg_wdata_out, .reg_wr_out, .reg_rd_out, .reg_rdata_in);
   host_model i_host (.core_clk_in, .tx_line_in(uart_tx_out), .sda_in, .rx_line_out(uart_rx_in),
      .scl_out(scl_in), .sda_drv_out(sda_drv));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   task automatic uart_txn(input logic [7:0] acc, input logic [7:0] dat, output logic [8:0] rb);
      fork
         begin
            i_host.uart_put(acc);
            if (!acc[0])
               i_host.uart_put(dat);
         end
         i_host.uart_get(rb);
      join
   endtask : uart_txn
   task automatic i2c_wr(input logic [7:0] b, input logic ea);
      logic [7:0] i;
      logic ak;
      i_host.i2c_byte(b, 1'b1, i, ak);
      chk(ak, ea);
   endtask : i2c_wr
   initial
   begin
      #360000;
      fail_count++;
      tally_and_finish();
   end
   // ----------------
   // tests
   // ----------------
   initial
   begin
      logic [8:0] rb;
      logic [7:0] d;
      logic [6:0] a;
      logic [6:0] dv;
      int r;
      r = $urandom(32'hE0A6);
      adr_pins_in = 2'($urandom);
      adr_nv_in = 2'($urandom);
      adr_use_nv_in = 1'($urandom);
      repeat (12) @(posedge core_clk_in);
      #1 rst_n_in = 1'b1;
      i_host.tk(2);
      foreach (spd[k])
      begin
         serial_speed_setting_in = spd[k];
         i_host.bt = bit_cyc(spd[k]);
         a = 7'($urandom);
         d = 8'($urandom);
         uart_txn({a, 1'b0}, d, rb);
         chk(rb, {1'b1, a, 1'b0});
         chk(wq.pop_front(), {a, d});
         uart_txn({a, 1'b1}, d, rb);
         chk(rb, {1'b1, mem_val(a)});
         $display("uart test at speed %h done", spd[k]);
      end
      uart_read_trigger_pin_in = 1'b0;
      uart_txn({a, 1'b1}, d, rb);
      chk(rb, 9'h000);
      uart_read_trigger_pin_in = 1'b1;
      $display("uart trigger test done");
      i2c_mode_in = 1'b1;
      i_host.tk(30);
      for (int k = 0; k < 2; k++)
      begin
         a = k ? {2'b01, a[4:0]} : FIFO_ADDR;
         adr_use_nv_in = ~adr_use_nv_in;
         dv = {5'h0A, adr_use_nv_in ? adr_nv_in : adr_pins_in};
         i_host.i2c_s();
         i2c_wr({dv, 1'b0}, 1'b0);
         i2c_wr({1'b0, a}, 1'b0);
         i2c_wr(d, 1'b0);
         i2c_wr(~d, 1'b0);
         i_host.i2c_p();
         chk(wq.pop_front(), {a, d});
         chk(wq.pop_front(), {(a == FIFO_ADDR) ? a : a + 7'h01, ~d});
         i_host.i2c_s();
         i2c_wr(k ? {dv ^ 7'h01, 1'b0} : 8'h00, 1'b1);
         i_host.i2c_p();
         $display("i2c write test %0d done", k);
      end
      i_host.i2c_s();
      i2c_wr({dv, 1'b0}, 1'b0);
      i2c_wr({1'b0, a}, 1'b0);
      i_host.i2c_s();
      i2c_wr({dv, 1'b1}, 1'b0);
      for (int k = 0; k < 2; k++)
      begin
         i_host.i2c_byte(8'hFF, k[0], rb[7:0], rb[8]);
         chk(rb[7:0], mem_val(a + k[6:0]));
      end
      chk(sda_in, 1'b1);
      i_host.i2c_p();
      $display("i2c read test done");
      tally_and_finish();
   end
endmodule : tb_top
